// ===== logic/sscr_regs.svh
// constants of the sensor command/response block
`ifndef SSCR_REGS_SVH
`define SSCR_REGS_SVH

// ----------------------------------------------------------------
// frame
// ----------------------------------------------------------------
`define SSCR_FRAME_BITS   5'd16
`define SSCR_CNT_MAX      5'd31
`define SSCR_OP_HI        15
`define SSCR_OP_LO        14
`define SSCR_ROP_HI       13
`define SSCR_ROP_LO       12
`define SSCR_PAYLOAD_HI   7
`define SSCR_REG_PAR_BIT  10
`define SSCR_ACC_PAR_BIT  12

// ----------------------------------------------------------------
// operation selector and register operations
// ----------------------------------------------------------------
`define SSCR_OP_REG       2'h0
`define SSCR_OP_X         2'h1
`define SSCR_OP_Y         2'h2
`define SSCR_OP_BAD       2'h3
`define SSCR_ROP_PTR_RD   2'h0
`define SSCR_ROP_PTR_WR   2'h1
`define SSCR_ROP_DAT_RD   2'h2
`define SSCR_ROP_DAT_WR   2'h3

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
`define SSCR_ADDR_DEVICE_CONTROL  8'h0e
`define SSCR_DEVICE_CONTROL_RST   8'h00
`define SSCR_DEVICE_CONTROL_CE    7
`define SSCR_DEVICE_CONTROL_ST_HI 1
`define SSCR_DEVICE_CONTROL_ST_LO 0
`define SSCR_RD_UNMAPPED  8'h00

// ----------------------------------------------------------------
// exception classes and codes
// ----------------------------------------------------------------
`define SSCR_EC_NONE      2'h0
`define SSCR_EC_BEH       2'h1
`define SSCR_EC_CRIT      2'h2
`define SSCR_EC_TRANS     2'h3
`define SSCR_STAT_ONES    3'h7
`define SSCR_STAT_NONE    3'h0
`define SSCR_CRIT_WORD    16'hfffe
`define SSCR_CODE_CRIT    11'h7ff
`define SSCR_CODE_AXIS    11'h7fe
`define SSCR_CODE_OVF     11'h7fd
`define SSCR_CODE_OVR     11'h7fc
`define SSCR_CODE_MAX     11'h7fb
`define SSCR_CODE_ZERO    11'h400
`define SSCR_CODE_MIN     11'h005
`define SSCR_CODE_UDR     11'h004
`define SSCR_CODE_UDF     11'h003
`define SSCR_CODE_CLK     11'h002
`define SSCR_CODE_PAR     11'h001
`define SSCR_STAT_CLK     8'h02
`define SSCR_STAT_PAR     8'h01
`define SSCR_STAT_AXIS    8'h03
`define SSCR_EMPTY_WORD   16'h0000

`endif

// ===== logic/sscr_pkg.sv
// types of the sensor command/response block
`default_nettype none
package sscr_pkg;

	// one axis sample as delivered by the filter chain
	typedef struct packed {
		logic [10:0] raw;
		logic        ovf;
		logic        ovr;
		logic        udr;
		logic        udf;
	} sscr_sample_t;

	typedef enum logic [2:0] {
		SSCR_IDLE  = 3'h1,
		SSCR_SHIFT = 3'h2,
		SSCR_BUILD = 3'h4
	} sscr_state_t;

endpackage
`default_nettype wire

// ===== logic/sscr_sample_fmt.sv
// saturation coding, clamping and sign selection of one axis
`timescale 1ns/100ps
`default_nettype none
`include "sscr_regs.svh"
module sscr_sample_fmt (
	input  wire logic                  core_clk,  // device clock
	input  wire logic                  rst_b,     // async reset, low
	input  wire sscr_pkg::sscr_sample_t sample,   // raw sample and flags
	input  wire logic                  signedSel, // two's complement out
	output logic [10:0]                code_q     // coded sample
);
	logic [10:0] clamped;
	logic [10:0] code_d;

	assign clamped = (sample.raw < `SSCR_CODE_MIN) ? `SSCR_CODE_MIN :
		(sample.raw > `SSCR_CODE_MAX) ? `SSCR_CODE_MAX : sample.raw;
	assign code_d = sample.ovf ? `SSCR_CODE_OVF :
		sample.udf ? `SSCR_CODE_UDF :
		sample.ovr ? `SSCR_CODE_OVR :
		sample.udr ? `SSCR_CODE_UDR :
		signedSel ? (clamped ^ `SSCR_CODE_ZERO) : clamped;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			code_q <= `SSCR_CODE_ZERO;
		end else begin
			code_q <= code_d;
		end
	end
endmodule // sscr_sample_fmt
`default_nettype wire

// ===== logic/sscr_resp_buf.sv
// two-entry response buffer with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module sscr_resp_buf (
	input  wire logic        core_clk, // device clock
	input  wire logic        rst_b,    // async reset, low
	input  wire logic        inVal,    // word offered
	output logic             inRdy,    // room for a word
	input  wire logic [15:0] inData,   // word in
	output logic             outVal,   // word available
	input  wire logic        outRdy,   // word taken
	output logic [15:0]      outData   // head word
);
	logic [15:0] mem_q [2];
	logic        wrPtr_q;
	logic        rdPtr_q;
	logic [1:0]  cnt_q;
	logic        doPush;
	logic        doPop;

	assign inRdy   = (cnt_q != 2'h2);
	assign outVal  = (cnt_q != 2'h0);
	assign outData = mem_q[rdPtr_q];
	assign doPush  = inVal & inRdy;
	assign doPop   = outVal & outRdy;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			mem_q[0] <= 16'h0000;
			mem_q[1] <= 16'h0000;
			wrPtr_q  <= 1'b0;
			rdPtr_q  <= 1'b0;
			cnt_q    <= 2'h0;
		end else begin
			if (doPush) begin
				mem_q[wrPtr_q] <= inData;
				wrPtr_q        <= ~wrPtr_q;
			end
			if (doPop) begin
				rdPtr_q <= ~rdPtr_q;
			end
			cnt_q <= cnt_q + {1'b0, doPush} - {1'b0, doPop};
		end
	end
endmodule // sscr_resp_buf
`default_nettype wire

// ===== logic/sscr_core.sv
// serial command decoder and response framer of the two-axis sensor
`timescale 1ns/100ps
`default_nettype none
`include "sscr_regs.svh"
module sscr_core (
	input  wire logic                   core_clk,        // 20 MHz device clock
	input  wire logic                   rst_b,           // async reset, low
	input  wire logic                   spiCsB,          // chip select, low
	input  wire logic                   spiSclk,         // serial clock
	input  wire logic                   spiMosi,         // serial data in
	output logic                        spiMiso,         // serial data out
	input  wire logic                   captureFreezeIn, // freeze level
	input  wire logic                   signedSampleSel, // signed samples
	input  wire logic                   initBusy,        // init in progress
	input  wire logic                   critFault,       // critical fault
	input  wire logic                   oscFault,        // oscillator fault
	input  wire sscr_pkg::sscr_sample_t xSample,         // X axis sample
	input  wire sscr_pkg::sscr_sample_t ySample,         // Y axis sample
	output logic [7:0]                  deviceControl,   // control register
	output logic                        selftestActive,  // self-test on
	output logic                        clearExcPulse    // clear-exception pulse
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	sscr_pkg::sscr_state_t state_q, state_d;
	logic        csPrev_q, sclkPrev_q;
	logic [15:0] rx_q;
	logic [15:0] tx_q;
	logic [4:0]  edgeCnt_q;
	logic        sclkHiAtCs_q;
	logic        miso_q;
	logic [7:0]  ptr_q;
	logic [7:0]  device_control_q;
	logic        selftest_q;
	logic        clrPulse_q;
	logic        devRes_q;
	logic [15:0] resp_q;
	logic        pushPend_q;
	logic [10:0] axisCode [2];

	// ----------------------------------------------------------------
	// edge detection
	// ----------------------------------------------------------------
	logic csFall, csRise, sclkRise, sclkFall;
	assign csFall   = csPrev_q & ~spiCsB;
	assign csRise   = ~csPrev_q & spiCsB;
	assign sclkRise = ~sclkPrev_q & spiSclk & ~spiCsB;
	assign sclkFall = sclkPrev_q & ~spiSclk & ~spiCsB;

	// ----------------------------------------------------------------
	// sample formatting, one per axis
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_axis
			sscr_sample_fmt u_fmt (
				.core_clk  (core_clk),
				.rst_b     (rst_b),
				.sample    ((gi == 0) ? xSample : ySample),
				.signedSel (signedSampleSel),
				.code_q    (axisCode[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	logic [1:0] opSel, regOp;
	logic [7:0] cmdPayload;
	logic       isReg;
	assign opSel      = rx_q[`SSCR_OP_HI:`SSCR_OP_LO];
	assign regOp      = rx_q[`SSCR_ROP_HI:`SSCR_ROP_LO];
	assign cmdPayload = rx_q[`SSCR_PAYLOAD_HI:0];
	assign isReg      = (opSel == `SSCR_OP_REG);

	// ----------------------------------------------------------------
	// exception detection and priority
	// ----------------------------------------------------------------
	logic clkFault, parFault, axisFault, transient, critRes, beh1;
	logic [1:0]  excClass;
	logic [7:0]  transStat;
	logic [10:0] transCode;
	assign clkFault  = (edgeCnt_q != `SSCR_FRAME_BITS) | sclkHiAtCs_q;
	assign parFault  = ~(^rx_q);
	assign axisFault = (opSel == `SSCR_OP_BAD);
	// this frame's faults go into the next frame's reply
	assign transient = clkFault | parFault | axisFault;
	assign critRes   = critFault | initBusy | devRes_q;
	assign beh1      = selftest_q ^ captureFreezeIn;
	assign excClass  = transient ? `SSCR_EC_TRANS :
		critRes ? `SSCR_EC_CRIT :
		beh1 ? `SSCR_EC_BEH : `SSCR_EC_NONE;
	// fault codes by order of precedence
	assign transCode = clkFault ? `SSCR_CODE_CLK :
		parFault ? `SSCR_CODE_PAR : `SSCR_CODE_AXIS;
	assign transStat = clkFault ? `SSCR_STAT_CLK :
		parFault ? `SSCR_STAT_PAR : `SSCR_STAT_AXIS;

	// ----------------------------------------------------------------
	// register side
	// ----------------------------------------------------------------
	logic       writeOk, ptrWrite, ctlWrite;
	logic [7:0] readData;
	// no writes on a faulty transfer
	assign writeOk  = isReg & ~transient;
	assign ptrWrite = writeOk & (regOp == `SSCR_ROP_PTR_WR);
	// only the control register takes data
	assign ctlWrite = writeOk & (regOp == `SSCR_ROP_DAT_WR) &
		(ptr_q == `SSCR_ADDR_DEVICE_CONTROL);
	assign readData = (ptr_q == `SSCR_ADDR_DEVICE_CONTROL) ? device_control_q : `SSCR_RD_UNMAPPED;

	// ----------------------------------------------------------------
	// response framing
	// ----------------------------------------------------------------
	logic [10:0] accelSample;
	logic [15:0] accelNoPar, regNoPar, respNoPar, respWord;
	logic [7:0]  regPayload;
	logic [2:0]  regTop;
	logic        parApplies, parBit;

	assign accelSample = (opSel == `SSCR_OP_X) ? axisCode[0] : axisCode[1];
	assign accelNoPar = (excClass == `SSCR_EC_TRANS) ?
		{`SSCR_STAT_ONES, 1'b0, transCode, 1'b0} :
		{beh1, opSel, 1'b0, accelSample, 1'b0};

	assign regPayload =
		(excClass == `SSCR_EC_TRANS) ? transStat :
		(regOp == `SSCR_ROP_PTR_RD) ? ptr_q :
		(regOp == `SSCR_ROP_DAT_RD) ? readData :
		(regOp == `SSCR_ROP_DAT_WR) ? ptr_q : 8'h00;
	assign regTop = (excClass == `SSCR_EC_NONE) ? `SSCR_STAT_NONE : `SSCR_STAT_ONES;
	assign regNoPar = {regTop, regOp, 1'b0, excClass, regPayload};

	assign respNoPar = isReg ? regNoPar : accelNoPar;
	assign parApplies = ~(isReg & (regOp == `SSCR_ROP_PTR_WR) &
		(excClass != `SSCR_EC_TRANS));
	assign parBit = parApplies & ~(^respNoPar);

	always_comb begin
		respWord = respNoPar;
		if (!isReg && excClass == `SSCR_EC_CRIT) begin
			respWord = `SSCR_CRIT_WORD;
		end else if (isReg) begin
			respWord[`SSCR_REG_PAR_BIT] = parBit;
		end else begin
			respWord[`SSCR_ACC_PAR_BIT] = parBit;
		end
	end

	// ----------------------------------------------------------------
	// response buffer
	// ----------------------------------------------------------------
	logic        bufInRdy, bufOutVal;
	logic [15:0] bufOutData;
	sscr_resp_buf u_buf (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.inVal    (pushPend_q),
		.inRdy    (bufInRdy),
		.inData   (resp_q),
		.outVal   (bufOutVal),
		.outRdy   (csFall),
		.outData  (bufOutData)
	);

	// ----------------------------------------------------------------
	// frame sequencing
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
			sscr_pkg::SSCR_IDLE: begin
				if (csFall) begin
					state_d = sscr_pkg::SSCR_SHIFT;
				end
			end
			sscr_pkg::SSCR_SHIFT: begin
				if (csRise) begin
					state_d = sscr_pkg::SSCR_BUILD;
				end
			end
			sscr_pkg::SSCR_BUILD: begin
				// wait while the previous reply is still unaccepted
				if (!pushPend_q) begin
					state_d = sscr_pkg::SSCR_IDLE;
				end
			end
			default: begin
				state_d = sscr_pkg::SSCR_IDLE;
			end
		endcase
	end

	logic building;
	assign building = (state_q == sscr_pkg::SSCR_BUILD) & ~pushPend_q;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q    <= sscr_pkg::SSCR_IDLE;
			csPrev_q   <= 1'b1;
			sclkPrev_q <= 1'b0;
		end else begin
			state_q    <= state_d;
			csPrev_q   <= spiCsB;
			sclkPrev_q <= spiSclk;
		end
	end

	// ----------------------------------------------------------------
	// shifting
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_q         <= 16'h0000;
			tx_q         <= 16'h0000;
			edgeCnt_q    <= 5'h00;
			sclkHiAtCs_q <= 1'b0;
		end else if (csFall) begin
			rx_q         <= 16'h0000;
			tx_q         <= bufOutVal ? bufOutData : `SSCR_EMPTY_WORD;
			edgeCnt_q    <= 5'h00;
			sclkHiAtCs_q <= spiSclk;
		end else begin
			if (sclkRise) begin
				rx_q <= {rx_q[14:0], spiMosi};
				if (edgeCnt_q != `SSCR_CNT_MAX) begin
					edgeCnt_q <= edgeCnt_q + 5'h01;
				end
			end
			if (sclkFall) begin
				tx_q <= {tx_q[14:0], 1'b0};
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			miso_q <= 1'b0;
		end else begin
			miso_q <= ~spiCsB & (oscFault | tx_q[15]);
		end
	end

	// ----------------------------------------------------------------
	// register and reply update
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ptr_q      <= 8'h00;
			device_control_q   <= `SSCR_DEVICE_CONTROL_RST;
			selftest_q <= 1'b0;
			clrPulse_q <= 1'b0;
			devRes_q   <= 1'b1;
			resp_q     <= 16'h0000;
			pushPend_q <= 1'b0;
		end else begin
			clrPulse_q <= 1'b0;
			if (pushPend_q && bufInRdy) begin
				pushPend_q <= 1'b0;
			end
			if (building) begin
				resp_q     <= respWord;
				pushPend_q <= 1'b1;
				if (ptrWrite) begin
					ptr_q <= cmdPayload;
				end
				if (ctlWrite) begin
					device_control_q   <= cmdPayload;
					selftest_q <= |cmdPayload[`SSCR_DEVICE_CONTROL_ST_HI:`SSCR_DEVICE_CONTROL_ST_LO];
					clrPulse_q <= cmdPayload[`SSCR_DEVICE_CONTROL_CE];
					if (cmdPayload[`SSCR_DEVICE_CONTROL_CE] && !initBusy) begin
						devRes_q <= 1'b0;
					end
				end
			end
		end
	end

	assign spiMiso        = miso_q;
	assign deviceControl  = device_control_q;
	assign selftestActive = selftest_q;
	assign clearExcPulse  = clrPulse_q;
endmodule // sscr_core
`default_nettype wire

// ===== tb/sscr_core_asserts.sv
// concurrent checks on the ports of the sensor serial command block
`timescale 1ns/100ps
`default_nettype none
module sscr_core_asserts (
	input wire logic       core_clk,       // device clock
	input wire logic       rst_b,          // async reset, low
	input wire logic       spiCsB,         // chip select, low
	input wire logic       spiSclk,        // serial clock
	input wire logic       spiMiso,        // serial data out
	input wire logic       oscFault,       // oscillator fault
	input wire logic [7:0] deviceControl,  // control register
	input wire logic       selftestActive, // self-test on
	input wire logic       clearExcPulse   // clear-exception pulse
);
	// ------------------------------------------------------------
	// edge history
	// ------------------------------------------------------------
	logic       csPrev_q;
	logic       sclkPrev_q;
	logic [2:0] recent_q;
	// output bits may only move a few cycles after a select or clock fall
	wire logic  fallSeen = (csPrev_q & !spiCsB) | (sclkPrev_q & !spiSclk);
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			csPrev_q   <= 1'b1;
			sclkPrev_q <= 1'b0;
			recent_q   <= 3'h0;
		end else begin
			csPrev_q   <= spiCsB;
			sclkPrev_q <= spiSclk;
			recent_q   <= fallSeen ? 3'h4 : recent_q - {2'h0, |recent_q};
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	sequence s_idle;
		spiCsB [*3];
	endsequence
	sequence s_osc_sel;
		(!spiCsB && oscFault) [*4];
	endsequence

	a_idle_low: assert property (s_idle |-> !spiMiso)
		else $error("serial out not low while deselected");
	a_osc_high: assert property (s_osc_sel |-> spiMiso)
		else $error("serial out not high under oscillator fault");
	a_bit_edges: assert property (!spiCsB && $changed(spiMiso) |-> recent_q != 3'h0)
		else $error("serial out moved away from a clock fall");
	a_pulse_single: assert property (clearExcPulse |=> !clearExcPulse)
		else $error("clear pulse longer than one cycle");
	a_pulse_ce: assert property (clearExcPulse |-> deviceControl[7])
		else $error("clear pulse without clear bit");
	a_pulse_gap: assert property (clearExcPulse |-> spiCsB && $past(spiCsB) && $past(spiCsB, 2))
		else $error("clear pulse inside a frame");
	a_ctl_gap: assert property ($changed(deviceControl) |-> spiCsB && $past(spiCsB))
		else $error("control changed inside a frame");
	a_selftest_ctl: assert property (!spiCsB |-> selftestActive == (|deviceControl[1:0]))
		else $error("self-test flag differs from control");
endmodule // sscr_core_asserts

bind sscr_core sscr_core_asserts u_chk (
	.core_clk       (core_clk),
	.rst_b          (rst_b),
	.spiCsB         (spiCsB),
	.spiSclk        (spiSclk),
	.spiMiso        (spiMiso),
	.oscFault       (oscFault),
	.deviceControl  (deviceControl),
	.selftestActive (selftestActive),
	.clearExcPulse  (clearExcPulse)
);
`default_nettype wire

// ===== tb/sscr_spi_master.sv
// serial master model facing the sensor serial port
`timescale 1ns/100ps
`default_nettype none
module sscr_spi_master (
	input  wire logic core_clk, // device clock
	output logic      spiCsB,   // chip select, low
	output logic      spiSclk,  // serial clock
	output logic      spiMosi,  // serial data to device
	input  wire logic spiMiso   // serial data from device
);
	initial begin
		spiCsB = 1'b1;
		spiSclk = 1'b0;
		spiMosi = 1'b0;
	end
	task automatic xfer(input logic [16:0] cmd, input int nb, output logic [15:0] got);
		spiCsB <= 1'b0;
		for (int i = nb - 1; i >= 0; i--) begin
			spiMosi <= cmd[i];
			repeat (4) @(posedge core_clk);
			// only the first sixteen bits carry the reply; later ones are shifted-in zeros
			if (i >= nb - 16) begin
				got = {got[14:0], spiMiso};
			end
			spiSclk <= 1'b1;
			repeat (4) @(posedge core_clk);
			spiSclk <= 1'b0;
		end
		repeat (4) @(posedge core_clk);
		spiCsB <= 1'b1;
		// released data line flips so stale bits never look valid
		spiMosi <= ~spiMosi;
		repeat (6) @(posedge core_clk);
	endtask
endmodule // sscr_spi_master
`default_nettype wire

// ===== tb/tb_sscr_core.sv
// self-checking bench of the sensor serial command block
`timescale 1ns/100ps
`default_nettype none
`include "sscr_regs.svh"
module tb_sscr_core;
	logic                   core_clk, rst_b, spiCsB, spiSclk, spiMosi, spiMiso;
	logic                   captureFreezeIn, signedSampleSel, initBusy, critFault;
	logic                   oscFault, selftestActive, clearExcPulse, rstF, chk;
	logic [7:0]             deviceControl, ptr, ctl;
	logic [15:0]            expW, got;
	sscr_pkg::sscr_sample_t xSample, ySample;
	sscr_pkg::sscr_sample_t sat [7] = '{{11'h400, 4'h8}, {11'h400, 4'h4}, {11'h400, 4'h2},
		{11'h400, 4'h1}, {11'h400, 4'h9}, {11'h002, 4'h0}, {11'h7fe, 4'h0}};
	int                     errors, n_compared, pulses, pexp;

	sscr_core u_dut (
		.core_clk(core_clk), .rst_b(rst_b), .spiCsB(spiCsB), .spiSclk(spiSclk),
		.spiMosi(spiMosi), .spiMiso(spiMiso), .captureFreezeIn(captureFreezeIn),
		.signedSampleSel(signedSampleSel), .initBusy(initBusy), .critFault(critFault),
		.oscFault(oscFault), .xSample(xSample), .ySample(ySample),
		.deviceControl(deviceControl), .selftestActive(selftestActive),
		.clearExcPulse(clearExcPulse));
	sscr_spi_master u_master (.core_clk(core_clk), .spiCsB(spiCsB), .spiSclk(spiSclk),
		.spiMosi(spiMosi), .spiMiso(spiMiso));

	// ------------------------------------------------------------
	// expectations
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] e, input logic [15:0] s);
		n_compared++;
		if (s !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, e, s);
		end
	endtask
	function automatic logic [15:0] mk(logic [3:0] t, logic [7:0] d);
		return {t, 1'b0, ~^{t, d}, 2'h0, d};
	endfunction
	function automatic logic [10:0] scode(sscr_pkg::sscr_sample_t s);
		logic [10:0] r;
		r = s.raw < `SSCR_CODE_MIN ? `SSCR_CODE_MIN : s.raw > `SSCR_CODE_MAX ? `SSCR_CODE_MAX : s.raw;
		if (s.ovf) return `SSCR_CODE_OVF;
		if (s.udf) return `SSCR_CODE_UDF;
		if (s.ovr) return `SSCR_CODE_OVR;
		if (s.udr) return `SSCR_CODE_UDR;
		return signedSampleSel ? r ^ `SSCR_CODE_ZERO : r;
	endfunction
	function automatic logic [15:0] expw(logic [15:0] c, logic [1:0] ec, logic [10:0] cd,
		logic [7:0] pay);
		logic [15:0] w;
		if (c[15:14] == `SSCR_OP_REG) begin
			w = {ec == `SSCR_EC_NONE ? `SSCR_STAT_NONE : `SSCR_STAT_ONES, c[13:12], 1'b0, ec, pay};
			w[10] = ~^w;
		end else if (ec == `SSCR_EC_CRIT) begin
			w = `SSCR_CRIT_WORD;
		end else begin
			w = {ec != `SSCR_EC_NONE, ec == `SSCR_EC_TRANS ? 2'h3 : c[15:14], 1'b0, cd, 1'b0};
			w[12] = ~^w;
		end
		return w;
	endfunction
	task automatic frame(input logic [15:0] c, input int nb = 16);
		logic [1:0]  ec;
		logic [10:0] cd;
		logic [7:0]  pay;
		logic        tf;
		u_master.xfer({1'b0, c}, nb, got);
		if (chk) check("reply", expW, got);
		tf = nb != 16 || !(^c) || c[15:14] == `SSCR_OP_BAD;
		cd = nb != 16 ? `SSCR_CODE_CLK : !(^c) ? `SSCR_CODE_PAR : tf ? `SSCR_CODE_AXIS :
			scode(c[14] ? xSample : ySample);
		pay = nb != 16 ? `SSCR_STAT_CLK : !(^c) ? `SSCR_STAT_PAR : `SSCR_STAT_AXIS;
		if (!tf) case (c[13:12])
			`SSCR_ROP_PTR_RD: pay = ptr;
			`SSCR_ROP_PTR_WR: pay = 8'h00;
			`SSCR_ROP_DAT_RD: pay = ptr == `SSCR_ADDR_DEVICE_CONTROL ? ctl : `SSCR_RD_UNMAPPED;
			default: pay = ptr;
		endcase
		ec = tf ? `SSCR_EC_TRANS : (critFault | rstF | initBusy) ? `SSCR_EC_CRIT :
			(captureFreezeIn ^ (|ctl[1:0])) ? `SSCR_EC_BEH : `SSCR_EC_NONE;
		expW = expw(c, ec, cd, pay);
		chk = !oscFault;
		if (!tf && c[15:12] == 4'h1) ptr = c[7:0];
		if (!tf && c[15:12] == 4'h3 && ptr == `SSCR_ADDR_DEVICE_CONTROL) begin
			ctl = c[7:0];
			pexp += c[7];
			if (c[7] && !initBusy) rstF = 1'b0;
		end
		check("control", {8'h00, ctl}, {8'h00, deviceControl});
		check("selftest", {15'h0, |ctl[1:0]}, {15'h0, selftestActive});
	endtask
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// ------------------------------------------------------------
	// run
	// ------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	always @(posedge core_clk) if (clearExcPulse === 1'b1) pulses++;
	initial begin
		repeat (40000) @(posedge core_clk);
		errors++;
		stop_test();
	end
	initial begin
		{rst_b, captureFreezeIn, signedSampleSel, critFault, oscFault, chk} = '0;
		{initBusy, rstF, ptr, ctl} = {2'h3, 16'h0000};
		xSample = {11'h123, 4'h0};
		ySample = {11'h6a0, 4'h0};
		void'($urandom(32'hfcfb));
		repeat (20) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge core_clk);
		frame(16'h4000);
		check("first", `SSCR_EMPTY_WORD, got);
		frame(16'h0400);
		frame(mk(4'h1, `SSCR_ADDR_DEVICE_CONTROL));
		frame(mk(4'h3, 8'h80));
		initBusy <= 1'b0;
		frame(mk(4'h3, 8'h80));
		frame(16'h8000);
		$display("test reset done");
		frame(mk(4'h1, 8'h20));
		frame(mk(4'h3, 8'h55));
		frame(16'h2000);
		frame(16'h0400);
		frame(mk(4'h1, `SSCR_ADDR_DEVICE_CONTROL));
		frame(mk(4'h3, 8'h01));
		frame(16'h4000);
		frame(16'h2000);
		captureFreezeIn <= 1'b1;
		frame(16'h8000);
		frame(mk(4'h3, 8'h00));
		frame(mk(4'h1, `SSCR_ADDR_DEVICE_CONTROL));
		frame(16'h4000);
		captureFreezeIn <= 1'b0;
		$display("test registers done");
		frame(mk(4'h3, 8'h03) ^ 16'h0400);
		frame(16'hc001);
		frame(16'hc000);
		critFault <= 1'b1;
		frame(16'h0000, 17);
		frame(16'h4000);
		frame(16'h0400);
		frame(mk(4'h3, 8'h02));
		critFault <= 1'b0;
		frame(16'h2000);
		$display("test faults done");
		foreach (sat[i]) begin
			xSample <= sat[i];
			frame(16'h4000);
		end
		oscFault <= 1'b1;
		chk = 1'b0;
		frame(16'h4000);
		check("osc", 16'hffff, got);
		oscFault <= 1'b0;
		$display("test codes done");
		for (int i = 0; i < 40; i++) begin
			xSample <= {11'($urandom_range(5, 2043)), 4'h0};
			ySample <= {11'($urandom_range(5, 2043)), 4'h0};
			signedSampleSel <= 1'($urandom);
			case ($urandom_range(0, 5))
				0: frame(16'h4000);
				1: frame(16'h8000);
				2: frame(16'h0400);
				3: frame(mk(4'h1, 8'($urandom_range(0, 1) ? 14 : $urandom)));
				4: frame(16'h2000);
				default: frame(mk(4'h3, 8'($urandom)));
			endcase
		end
		frame(16'h0400);
		check("pulses", 16'(pexp), 16'(pulses));
		$display("test random done");
		stop_test();
	end
endmodule // tb_sscr_core
`default_nettype wire
